// ===== scpc_top.sv
// Purpose: chopper phase control for two bipolar steppers
// Assumes: bus strobes are single-cycle and synchronous to i_clk
// Assumes: comparator hits and home sensors are already clean and synchronous
// Notes: current limits feed external comparators on o_limit
// Notes: register map, 0..3 limits, 4 phase, 5 home and chop, 6 arm and 7 drop position
// Notes: phase byte, low nibble enables, high nibble selects reverse polarity
// Notes: winding i drives bit 2i forward and bit 2i+1 reverse
// Notes: windings 0 and 1 belong to the arm, 2 and 3 to the drop former
// Notes: position counters wrap at eight bits and are not cleared at home
// Notes: a comparator hit and a chopper tick in one cycle leave the phase off
// Notes: the live hit also gates the drive in the cycle it arrives
// Notes: the tick period is the integer part of the clock over the chopper rate
// Notes: writes to unmapped codes are ignored, reads of them return zero
// Notes: any read or write may follow another in the next cycle
// How it works
// - Two bipolar steppers are driven with microstepping and per-phase chopped current.
// - The processor writes a current limit for each of the four windings.
// - The processor writes which phases are on and the polarity of each.
// - A phase is switched off when its comparator says the set current is reached.
// - Each 94 kHz tick re-enables any off phase whose current is below its limit.
// - Eight drive outputs feed two dual H-bridges for both polarities of all windings.
// - Home sensors read high to the processor while the flag blocks the light.
// - The chopper tick is divided down from the system clock.
// - Registers are selected by decoded address with read and write strobes.
`timescale 1ns/10ps
`include "scpc_consts.svh"
`default_nettype none
module scpc_top
	import scpc_pkg::*;
(
	input wire logic i_clk, // system clock
	input wire logic i_rst_n, // sync reset, low
	input wire scpc_bus_t i_bus, // decoded processor access
	input wire logic [3:0] i_cmp_hit, // comparator: current reached
	input wire logic home_sensor_in_a, // arm home sensor
	input wire logic i_home_b, // drop former home sensor
	input wire logic [1:0] i_step_arm, // {dir,step} arm
	input wire logic [1:0] i_step_drop, // {dir,step} drop former
	output logic [7:0] o_rdata, // read data
	output scpc_drive_t o_drive, // h-bridge inputs
	output logic [31:0] o_limit, // four current limits
	output logic o_chop_tick // chopper clock tick
);
	logic [7:0] limit_r [0:3];
	logic [7:0] phase_r;
	logic [3:0] chop_off_r;
	logic [`SCPC_DIV_W-1:0] div_r;
	logic tick_r;
	logic [7:0] pos_arm_r;
	logic [7:0] pos_drop_r;
	logic [7:0] rdata_nxt;
	scpc_drive_t drive_nxt;

	// decoded write strobe for one register
	function automatic logic bus_wr_sel(input scpc_bus_t bus, input logic [3:0] addr);
		return bus.wr && (bus.addr == addr);
	endfunction : bus_wr_sel

	// bridge pair of one winding, forward in the low bit
	function automatic logic [1:0] bridge_pair(input logic en, input logic rev);
		logic [1:0] pair;
		pair = `SCPC_PAIR_OFF;
		if (en) begin
			pair = rev ? `SCPC_PAIR_REV : `SCPC_PAIR_FWD;
		end
		return pair;
	endfunction : bridge_pair

	// one step of a position counter, dir high counts down
	function automatic logic [7:0] step_next(input logic [7:0] pos, input logic [1:0] step);
		logic [7:0] nxt;
		nxt = pos;
		if (step[`SCPC_STEP_PULSE]) begin
			nxt = step[`SCPC_STEP_DIR] ? pos - 8'h01 : pos + 8'h01;
		end
		return nxt;
	endfunction : step_next

	// status byte: home sensors low, arm chop flags above
	function automatic logic [7:0] home_word(input logic [3:0] chop, input logic home_b,
		input logic home_a);
		logic [7:0] word;
		word = `SCPC_RD_IDLE;
		word[`SCPC_HOME_A_BIT] = home_a;
		word[`SCPC_HOME_B_BIT] = home_b;
		word[`SCPC_CHOP_LSB +: 2] = chop[1:0];
		return word;
	endfunction : home_word

	// chopper clock divider
	// wraps at the divide count minus one, so the period is the whole count
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (div_r == `SCPC_DIV_W'(`SCPC_CHOP_DIV - 1)) begin
			div_r <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + `SCPC_DIV_W'(1);
			tick_r <= 1'b0;
		end
	end

	// limit writes
	// one register per winding
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lim
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					limit_r[g] <= `SCPC_LIMIT_RST;
				end else if (bus_wr_sel(i_bus, `SCPC_ADDR_LIMIT0 + 4'(g))) begin
					limit_r[g] <= i_bus.wdata;
				end
			end
			assign o_limit[g*8 +: 8] = limit_r[g];
		end
	endgenerate

	// phase enable and polarity
	// takes effect on the bridges two cycles after the write
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			phase_r <= `SCPC_PHASE_RST;
		end else if (bus_wr_sel(i_bus, `SCPC_ADDR_PHASE)) begin
			phase_r <= i_bus.wdata;
		end
	end

	// chop latch, hit wins over tick
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			chop_off_r <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (i_cmp_hit[i]) begin
					chop_off_r[i] <= 1'b1;
				end else if (tick_r) begin
					// current fell below the limit, try again
					chop_off_r[i] <= 1'b0;
				end
			end
		end
	end

	always_comb begin
		drive_nxt = '0;
		for (int i = 0; i < 4; i++) begin
			// live hit gates at once, the latch holds it off afterwards
			drive_nxt[2*i +: 2] = bridge_pair(
				phase_r[`SCPC_PH_EN_LSB + i] && !chop_off_r[i] && !i_cmp_hit[i],
				phase_r[`SCPC_PH_POL_LSB + i]);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_drive <= '0;
		end else begin
			o_drive <= drive_nxt;
		end
	end

	// tick seen outside, one cycle late
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_chop_tick <= 1'b0;
		end else begin
			o_chop_tick <= tick_r;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pos_arm_r <= `SCPC_POS_RST;
		end else begin
			pos_arm_r <= step_next(pos_arm_r, i_step_arm);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pos_drop_r <= `SCPC_POS_RST;
		end else begin
			pos_drop_r <= step_next(pos_drop_r, i_step_drop);
		end
	end

	always_comb begin
		rdata_nxt = `SCPC_RD_IDLE;
		unique case (i_bus.addr)
			`SCPC_ADDR_LIMIT0,
			`SCPC_ADDR_LIMIT1,
			`SCPC_ADDR_LIMIT2,
			`SCPC_ADDR_LIMIT3: rdata_nxt = limit_r[i_bus.addr[1:0]];
			`SCPC_ADDR_PHASE: rdata_nxt = phase_r;
			`SCPC_ADDR_HOME: rdata_nxt = home_word(chop_off_r, i_home_b, home_sensor_in_a);
			`SCPC_ADDR_POS_ARM: rdata_nxt = pos_arm_r;
			`SCPC_ADDR_POS_DROP: rdata_nxt = pos_drop_r;
			// unmapped codes read as zero
			default: rdata_nxt = `SCPC_RD_IDLE;
		endcase
	end

	// read data holds until the next read
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= `SCPC_RD_IDLE;
		end else if (i_bus.rd) begin
			o_rdata <= rdata_nxt;
		end
	end
endmodule : scpc_top
`default_nettype wire

// ===== scpc_consts.svh
// Purpose: constants for the stepper chopper phase control block
// Assumes: 20 MHz system clock
// Notes: bus addresses are the decoder's low select codes
`ifndef SCPC_CONSTS_SVH
`define SCPC_CONSTS_SVH
`define SCPC_CLK_HZ 20000000
`define SCPC_CHOP_HZ 94000
`define SCPC_CHOP_DIV (`SCPC_CLK_HZ / `SCPC_CHOP_HZ)
`define SCPC_DIV_W 8
`define SCPC_ADDR_LIMIT0 4'h0
`define SCPC_ADDR_LIMIT1 4'h1
`define SCPC_ADDR_LIMIT2 4'h2
`define SCPC_ADDR_LIMIT3 4'h3
`define SCPC_ADDR_PHASE 4'h4
`define SCPC_ADDR_HOME 4'h5
`define SCPC_ADDR_POS_ARM 4'h6
`define SCPC_ADDR_POS_DROP 4'h7
`define SCPC_PH_EN_LSB 0
`define SCPC_PH_POL_LSB 4
`define SCPC_LIMIT_RST 8'h00
`define SCPC_PHASE_RST 8'h00
`define SCPC_POS_RST 8'h00
`define SCPC_RD_IDLE 8'h00
`define SCPC_HOME_A_BIT 0
`define SCPC_HOME_B_BIT 1
`define SCPC_CHOP_LSB 2
`define SCPC_STEP_PULSE 0
`define SCPC_STEP_DIR 1
`define SCPC_PAIR_OFF 2'h0
`define SCPC_PAIR_FWD 2'h1
`define SCPC_PAIR_REV 2'h2
`endif

// ===== scpc_pkg.sv
// Purpose: types for the stepper chopper phase control block
// Assumes: four windings, two per motor
// Notes: none
`default_nettype none
package scpc_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} scpc_bus_t;
	typedef logic [7:0] scpc_drive_t;
endpackage : scpc_pkg
`default_nettype wire

// ===== scpc_chk_props.sv
// Purpose: port assertions for scpc_top
// Assumes: sync low reset
// Notes: bound at foot
`timescale 1ns/10ps
`default_nettype none
module scpc_chk import scpc_pkg::*; (
	input wire logic i_clk, // clock
	input wire logic i_rst_n, // reset
	input wire scpc_bus_t i_bus, // bus
	input wire logic [3:0] i_cmp_hit, // hits
	input wire logic home_sensor_in_a, // home
	input wire logic i_home_b, // home
	input wire logic [7:0] o_rdata, // data
	input wire scpc_drive_t o_drive, // drive
	input wire logic [31:0] o_limit, // limits
	input wire logic o_chop_tick // tick
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	AST_GAP: assert property (o_chop_tick |-> ##212 o_chop_tick) else $error("gap");
	AST_OFF: assert property (i_cmp_hit[0] |=> o_drive[1:0] == 2'h0) else $error("off");
	AST_HOLD: assert property (i_cmp_hit[3] ##1 (!i_cmp_hit[3] && !o_chop_tick) [*2] |=>
		o_drive[7:6] == 2'h0) else $error("hold");
	AST_BRIDGE: assert property ((o_drive & (o_drive >> 1) & 8'h55) == 8'h00) else $error("both");
	AST_LIMIT: assert property (i_bus.wr && i_bus.addr < 4'h4 |=>
		o_limit[$past(i_bus.addr[1:0]) * 8 +: 8] == $past(i_bus.wdata)) else $error("limit");
	AST_HOME: assert property (i_bus.rd && i_bus.addr == 4'h5 |=>
		o_rdata[1:0] == {$past(i_home_b), $past(home_sensor_in_a)}) else $error("home");
	AST_KEEP: assert property (!i_bus.rd |=> $stable(o_rdata)) else $error("keep");
	AST_VOID: assert property (i_bus.rd && i_bus.addr[3] |=> o_rdata == 8'h00) else $error("void");
endmodule : scpc_chk
bind scpc_top scpc_chk i_scpc_chk (.*);
`default_nettype wire

// ===== scpc_host.sv
// Purpose: host bus model
// Assumes: called just after an edge
// Notes: one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module scpc_host import scpc_pkg::*; (
	input wire logic i_clk, // clock
	output var scpc_bus_t o_bus // bus
);
	initial o_bus = '0;
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
		o_bus = '{a, d, w, !w};
		@(posedge i_clk);
		#1 o_bus = '{~a, ~d, 1'b0, 1'b0};
		@(posedge i_clk);
		#1;
	endtask : acc
endmodule : scpc_host
`default_nettype wire

// ===== scpc_tb.sv
// Purpose: bench for scpc_top
// Assumes: host model drives bus
// Notes: lfsr data
`timescale 1ns/10ps
`default_nettype none
module testbench import scpc_pkg::*;;
	logic clk = 0, rst_n = 0, ha = 0, hb = 0, tick;
	logic [3:0] hit = '0;
	logic [7:0] rd, d, ed, el [4];
	logic [31:0] lim, rs = 32'hcfdeb3f8;
	scpc_bus_t bus;
	scpc_drive_t drv;
	int error_cnt = 0, check_count = 0, n, k, pa = 0, pd = 0;
	logic [1:0] sa = '0, sd = '0;
	scpc_host i_scpc_host (.i_clk(clk), .o_bus(bus));
	scpc_top i_scpc_top (.i_clk(clk), .i_rst_n(rst_n), .i_bus(bus), .i_cmp_hit(hit),
		.home_sensor_in_a(ha), .i_home_b(hb), .i_step_arm(sa), .i_step_drop(sd),
		.o_rdata(rd), .o_drive(drv), .o_limit(lim), .o_chop_tick(tick));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk(input string m, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", m, e, s);
		end
	endtask : chk
	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wtick();
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (!tick && n < 300);
	endtask : wtick
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	initial forever #25 clk = ~clk;
	initial begin
		#1000000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		cyc(2);
		rst_n = 1;
		chk("reset", {rd, drv, lim[15:0]}, 32'h0);
		for (n = 0; n < 4; n++) begin
			rs = lfsr(rs);
			el[n] = rs[7:0];
			i_scpc_host.acc(1, n[3:0], el[n]);
			i_scpc_host.acc(0, n[3:0], 8'h0);
			chk("rdlim", rd, el[n]);
		end
		i_scpc_host.acc(1, 4'h9, 8'hff);
		i_scpc_host.acc(0, 4'hc, 8'h0);
		chk("void", rd, 0);
		chk("limit", lim, {el[3], el[2], el[1], el[0]});
		for (n = 0; n < 4; n++) begin
			rs = lfsr(rs);
			d = rs[7:0];
			ed = 0;
			for (k = 0; k < 4; k++) ed[2 * k + d[4 + k]] = d[k];
			i_scpc_host.acc(1, 4'h4, d);
			cyc(2);
			chk("drive", drv, ed);
			i_scpc_host.acc(0, 4'h4, 8'h0);
			chk("rdph", rd, d);
		end
		i_scpc_host.acc(1, 4'h4, 8'h09);
		cyc(2);
		hit = 4'h9;
		cyc(1);
		hit = 4'h0;
		chk("chop", drv, 0);
		wtick();
		wtick();
		chk("period", n, 212);
		chk("reon", drv, 8'h41);
		for (k = 0; k < 4; k++) begin
			{hb, ha} = k[1:0];
			i_scpc_host.acc(0, 4'h5, 8'h0);
			chk("home", rd, k);
		end
		for (n = 0; n < 40; n++) begin
			rs = lfsr(rs);
			{sd, sa} = rs[3:0];
			pa += sa[0] ? (sa[1] ? -1 : 1) : 0;
			pd += sd[0] ? (sd[1] ? -1 : 1) : 0;
			cyc(1);
		end
		{sd, sa} = 4'h0;
		i_scpc_host.acc(0, 4'h6, 8'h0);
		chk("posarm", rd, pa[7:0]);
		i_scpc_host.acc(0, 4'h7, 8'h0);
		chk("posdrop", rd, pd[7:0]);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
